// ===== rtl/reset_monitor_pkg.sv
// Constants and types for the reset source and supply monitor block
//
// Notes on behaviour
// R01: Low level on the external reset pin forces the internal reset.
// R02: Power-on reset holds until supply passes threshold plus a fixed delay.
// R03: Each of three monitor channels may reset when supply falls below threshold.
// R04: A deep-standby wake interrupt issues a deep-standby reset.
// R05: Independent watchdog underflow or refresh error asserts reset.
// R06: Main watchdog underflow or refresh error asserts reset.
// R07: A software write of the request key produces a software reset.
// R08: Channel 0 reset output is enabled by an option-memory setting.
// R09: Channels 1 and 2 filter detect inputs, sampling at oscillator /2, /4, /8, /16.
// R10: Monitor resets offer two release timings after supply recovers; channel 0 has only the fixed delay.
// R11: Software picks rising or falling supply as the detection event.
// R12: Detection routes to maskable or non-maskable interrupt, plus an event-link output.
// R13: Internal reset is the OR of enabled sources, released when all clear.
package reset_monitor_pkg;

  // ==========================================================================
  // Register offsets (plain port, byte addresses)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CH1_CFG  = 8'h04;
  localparam logic [7:0] ADDR_CH2_CFG  = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;
  localparam logic [7:0] ADDR_SW_RESET = 8'h10;

  // ==========================================================================
  // Field positions of the channel configuration register
  localparam int CFG_RST_EN    = 0;
  localparam int CFG_INT_EN    = 1;
  localparam int CFG_NMI_SEL   = 2;
  localparam int CFG_RISE_SEL  = 3;
  localparam int CFG_REL_AFTER = 4;
  localparam int CFG_FLT_EN    = 5;
  localparam int CFG_DIV_LO    = 6;
  localparam int CFG_DIV_W     = 2;
  localparam int CFG_W         = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  // Control register: status flag clear bits for channels 1 and 2
  localparam int CTRL_CLR1 = 0;
  localparam int CTRL_CLR2 = 1;

  // Software reset key, low byte of a write to ADDR_SW_RESET
  localparam logic [7:0] SW_RESET_KEY = 8'ha5;

  // ==========================================================================
  // Timing
  localparam int CLOCK_HZ        = 10_000_000;
  localparam int POR_DELAY_US    = 1000;
  localparam int POR_DELAY_CYC   = (POR_DELAY_US * (CLOCK_HZ / 1_000_000));
  localparam int MON_DELAY_US    = 100;
  localparam int MON_DELAY_CYC   = (MON_DELAY_US * (CLOCK_HZ / 1_000_000));
  localparam int FILTER_SAMPLES  = 3;

  // Status register bit positions
  localparam int ST_FLAG1 = 0;
  localparam int ST_FLAG2 = 1;
  localparam int ST_MON1  = 2;
  localparam int ST_MON2  = 3;
  localparam int ST_RST   = 4;

  typedef enum logic [0:0] {
    REL_AFTER_RECOVERY,
    REL_ON_SOFTWARE
  } release_mode_t;

endpackage : reset_monitor_pkg

// ===== rtl/monitor_channel.sv
// One filtered supply monitor channel with reset, interrupt and event output
`timescale 1ns/10ps
`default_nettype none
module monitor_channel
  import reset_monitor_pkg::*;
#(
  parameter int DELAY_CYC = MON_DELAY_CYC
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             osc_tick,
  input  wire logic [CFG_W-1:0] cfg,
  input  wire logic             below,
  input  wire logic             flag_clr,
  output logic                  mon_level,
  output logic                  flag_reg,
  output logic                  reset_req,
  output logic                  event_pulse
);

  // Refused at elaboration: a zero delay leaves the release counter without an end
  if (DELAY_CYC < 1) begin : g_bad_delay
    $error("monitor_channel: DELAY_CYC must be at least one");
  end

  // ==========================================================================
  // Oscillator divider and sampling filter
  logic [3:0]                 div_reg;
  logic                       samp;
  logic [FILTER_SAMPLES-1:0]  hist_reg;
  logic                       filt_reg;
  logic                       prev_reg;
  logic [$clog2(DELAY_CYC+1)-1:0] rel_cnt_reg;
  logic                       hold_reg;
  logic                       detect;

  always_comb begin
    case (cfg[CFG_DIV_LO +: CFG_DIV_W])
      2'h0:    samp = osc_tick & div_reg[0];
      2'h1:    samp = osc_tick & (&div_reg[1:0]);
      2'h2:    samp = osc_tick & (&div_reg[2:0]);
      default: samp = osc_tick & (&div_reg);
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) div_reg <= 4'h0;
    else if (osc_tick) div_reg <= div_reg + 4'h1;
  end

  // Filtered level only changes after all samples agree; bypass when disabled
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hist_reg <= '0;
      filt_reg <= 1'b0;
    end else if (!cfg[CFG_FLT_EN]) begin
      hist_reg <= {FILTER_SAMPLES{below}};
      filt_reg <= below;
    end else if (samp) begin // R09
      hist_reg <= {hist_reg[FILTER_SAMPLES-2:0], below};
      if (&{hist_reg[FILTER_SAMPLES-2:0], below}) filt_reg <= 1'b1;
      else if (~|{hist_reg[FILTER_SAMPLES-2:0], below}) filt_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Edge selection, sticky flag and event link
  always_comb begin
    if (cfg[CFG_RISE_SEL]) detect = prev_reg & ~filt_reg; // R11
    else detect = ~prev_reg & filt_reg;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) prev_reg <= 1'b0;
    else prev_reg <= filt_reg;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) flag_reg <= 1'b0;
    else if (detect) flag_reg <= 1'b1; // Set wins over clear
    else if (flag_clr) flag_reg <= 1'b0;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) event_pulse <= 1'b0;
    else event_pulse <= detect & cfg[CFG_INT_EN]; // R12
  end

  always_ff @(posedge clock) begin
    if (sys_rst) mon_level <= 1'b0;
    else mon_level <= filt_reg;
  end

  // ==========================================================================
  // Reset request with two release timings
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_reg    <= 1'b0;
      rel_cnt_reg <= '0;
    end else if (cfg[CFG_RST_EN] && filt_reg) begin // R03
      hold_reg    <= 1'b1;
      rel_cnt_reg <= ($clog2(DELAY_CYC+1))'(DELAY_CYC);
    end else if (hold_reg) begin
      // R10: either release a fixed delay after recovery or on detected recovery
      if (cfg[CFG_REL_AFTER] == REL_ON_SOFTWARE) hold_reg <= 1'b0;
      else if (rel_cnt_reg <= 1) hold_reg <= 1'b0;
      else rel_cnt_reg <= rel_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) reset_req <= 1'b0;
    else reset_req <= (cfg[CFG_RST_EN] && filt_reg) || hold_reg;
  end

endmodule : monitor_channel
`default_nettype wire

// ===== rtl/reset_monitor.sv
// Reset source combiner and supply-voltage monitor top
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module reset_monitor
  import reset_monitor_pkg::*;
#(
  parameter int POR_CYC = POR_DELAY_CYC,
  parameter int MON_CYC = MON_DELAY_CYC
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       external_reset_pin_n,
  input  wire logic       supply_above_por,
  input  wire logic       ch0_below,
  input  wire logic       ch1_below,
  input  wire logic       ch2_below,
  input  wire logic       ch0_reset_opt,
  input  wire logic       low_speed_onchip_osc_tick,
  input  wire logic       deep_standby_wake,
  input  wire logic       independent_watchdog_underflow,
  input  wire logic       independent_watchdog_refresh_err,
  input  wire logic       main_watchdog_underflow,
  input  wire logic       main_watchdog_refresh_err,
  input  wire logic [7:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic [31:0]     rdata,
  output logic            internal_reset,
  output logic            maskable_irq,
  output logic            nonmaskable_irq,
  output logic            event_link_1,
  output logic            event_link_2,
  output logic [7:0]      reset_cause
);

  if (POR_CYC < 1 || MON_CYC < 1) begin : g_bad_delay
    $error("reset_monitor: delays must be at least one");
  end

  // ==========================================================================
  // Configuration registers
  logic [CFG_W-1:0] ch1_cfg_reg;
  logic [CFG_W-1:0] ch2_cfg_reg;
  logic             clr1;
  logic             clr2;
  logic             sw_req;
  logic             ch1_flag;
  logic             ch2_flag;
  logic             ch1_mon;
  logic             ch2_mon;
  logic             ch1_rst;
  logic             ch2_rst;
  logic             ch1_evt;
  logic             ch2_evt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ch1_cfg_reg <= CFG_RESET;
      ch2_cfg_reg <= CFG_RESET;
    end else if (wr_stb) begin
      if (hit(addr, ADDR_CH1_CFG)) ch1_cfg_reg <= wdata[CFG_W-1:0];
      else if (hit(addr, ADDR_CH2_CFG)) ch2_cfg_reg <= wdata[CFG_W-1:0];
    end
  end

  assign clr1   = wr_stb && hit(addr, ADDR_CTRL) && wdata[CTRL_CLR1];
  assign clr2   = wr_stb && hit(addr, ADDR_CTRL) && wdata[CTRL_CLR2];
  // Key guards against stray writes resetting the chip
  assign sw_req = wr_stb && hit(addr, ADDR_SW_RESET) && (wdata[7:0] == SW_RESET_KEY); // R07

  // ==========================================================================
  // Monitor channels 1 and 2
  monitor_channel #(.DELAY_CYC(MON_CYC)) u_ch1 (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .osc_tick    (low_speed_onchip_osc_tick),
    .cfg         (ch1_cfg_reg),
    .below       (ch1_below),
    .flag_clr    (clr1),
    .mon_level   (ch1_mon),
    .flag_reg    (ch1_flag),
    .reset_req   (ch1_rst),
    .event_pulse (ch1_evt)
  );

  monitor_channel #(.DELAY_CYC(MON_CYC)) u_ch2 (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .osc_tick    (low_speed_onchip_osc_tick),
    .cfg         (ch2_cfg_reg),
    .below       (ch2_below),
    .flag_clr    (clr2),
    .mon_level   (ch2_mon),
    .flag_reg    (ch2_flag),
    .reset_req   (ch2_rst),
    .event_pulse (ch2_evt)
  );

  // ==========================================================================
  // Power-on and channel 0 hold timers
  logic [$clog2(POR_CYC+1)-1:0] por_cnt_reg;
  logic                         por_active_reg;
  logic [$clog2(MON_CYC+1)-1:0] ch0_cnt_reg;
  logic                         ch0_active_reg;
  logic                         sw_hold_reg;
  logic [7:0]                   src;
  logic                         any_src;

  // Counter only starts once the supply is above the detect level
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      por_active_reg <= 1'b1;
      por_cnt_reg    <= '0;
    end else if (!supply_above_por) begin // R02
      por_active_reg <= 1'b1;
      por_cnt_reg    <= '0;
    end else if (por_active_reg) begin
      if (por_cnt_reg >= ($clog2(POR_CYC+1))'(POR_CYC - 1)) por_active_reg <= 1'b0;
      else por_cnt_reg <= por_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ch0_active_reg <= 1'b0;
      ch0_cnt_reg    <= '0;
    end else if (ch0_reset_opt && ch0_below) begin // R08 R03
      ch0_active_reg <= 1'b1;
      ch0_cnt_reg    <= ($clog2(MON_CYC+1))'(MON_CYC);
    end else if (ch0_active_reg) begin // R10
      if (ch0_cnt_reg <= 1) ch0_active_reg <= 1'b0;
      else ch0_cnt_reg <= ch0_cnt_reg - 1'b1;
    end
  end

  // Software request is a strobe; hold it one cycle so the combiner sees it
  always_ff @(posedge clock) begin
    if (sys_rst) sw_hold_reg <= 1'b0;
    else sw_hold_reg <= sw_req;
  end

  // ==========================================================================
  // Source combination
  always_comb begin
    src[0] = ~external_reset_pin_n; // R01
    src[1] = por_active_reg;
    src[2] = ch0_active_reg;
    src[3] = ch1_rst;
    src[4] = ch2_rst;
    src[5] = deep_standby_wake; // R04
    src[6] = independent_watchdog_underflow | independent_watchdog_refresh_err; // R05
    src[7] = main_watchdog_underflow | main_watchdog_refresh_err | sw_hold_reg; // R06 R07
    any_src = |src;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) internal_reset <= 1'b1;
    else internal_reset <= any_src; // R13
  end

  // Cause bits stick until the next system reset so software can read them
  always_ff @(posedge clock) begin
    if (sys_rst) reset_cause <= 8'h00;
    else reset_cause <= reset_cause | src;
  end

  // ==========================================================================
  // Interrupt routing and event link
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      maskable_irq    <= 1'b0;
      nonmaskable_irq <= 1'b0;
      event_link_1    <= 1'b0;
      event_link_2    <= 1'b0;
    end else begin
      maskable_irq    <= (ch1_evt & ~ch1_cfg_reg[CFG_NMI_SEL])
                       | (ch2_evt & ~ch2_cfg_reg[CFG_NMI_SEL]); // R12
      nonmaskable_irq <= (ch1_evt & ch1_cfg_reg[CFG_NMI_SEL])
                       | (ch2_evt & ch2_cfg_reg[CFG_NMI_SEL]);
      event_link_1    <= ch1_evt;
      event_link_2    <= ch2_evt;
    end
  end

  // ==========================================================================
  // Read port; unmapped addresses return zero
  always_ff @(posedge clock) begin
    if (sys_rst) rdata <= 32'h0000_0000;
    else if (rd_stb) begin
      if (hit(addr, ADDR_CH1_CFG)) rdata <= {24'h000000, ch1_cfg_reg};
      else if (hit(addr, ADDR_CH2_CFG)) rdata <= {24'h000000, ch2_cfg_reg};
      else if (hit(addr, ADDR_STATUS))
        rdata <= {19'h00000, reset_cause, internal_reset, ch2_mon, ch1_mon, ch2_flag, ch1_flag};
      else rdata <= 32'h0000_0000;
    end else rdata <= 32'h0000_0000;
  end

endmodule : reset_monitor
`default_nettype wire

// ===== verification/osc_tick_model.sv
// Low-speed oscillator tick source driving the monitor filters
`timescale 1ns/10ps
`default_nettype none
module osc_tick_model #(
  parameter int PERIOD = 4
) (
  input  wire logic clock,
  output var logic  tick
);
  int count = 0;
  // Free running: the oscillator keeps ticking whether or not a detect is pending
  always_ff @(posedge clock) begin
    count <= (count == PERIOD - 1) ? 0 : count + 1;
  end
  assign tick = (count == PERIOD - 1);
endmodule : osc_tick_model
`default_nettype wire

// ===== verification/reset_monitor_sva.sv
// Concurrent checks on the reset monitor ports
`timescale 1ns/10ps
`default_nettype none
module reset_monitor_sva
  import reset_monitor_pkg::*;
#(
  parameter int POR_CYC = POR_DELAY_CYC,
  parameter int MON_CYC = MON_DELAY_CYC
) (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        external_reset_pin_n,
  input wire logic        supply_above_por,
  input wire logic        ch0_below,
  input wire logic        ch0_reset_opt,
  input wire logic        deep_standby_wake,
  input wire logic        independent_watchdog_underflow,
  input wire logic        independent_watchdog_refresh_err,
  input wire logic        main_watchdog_underflow,
  input wire logic        main_watchdog_refresh_err,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        internal_reset,
  input wire logic        maskable_irq,
  input wire logic        nonmaskable_irq,
  input wire logic [7:0]  reset_cause
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Source to reset relations and interrupt pulse shape
  sequence sw_key;
    wr_stb && addr == ADDR_SW_RESET && wdata[7:0] == SW_RESET_KEY;
  endsequence
  sequence irq_any;
    maskable_irq || nonmaskable_irq;
  endsequence
  a_pin_forces_reset: assert property (
    !external_reset_pin_n |=> internal_reset && reset_cause[0])
    else $error("pin low did not force reset");
  a_por_holds: assert property (
    $rose(supply_above_por) |-> internal_reset [*8])
    else $error("power-on reset released too early");
  a_ch0_reset: assert property (
    ch0_below && ch0_reset_opt |-> ##[1:3] internal_reset)
    else $error("channel 0 detect gave no reset");
  a_deep_standby_reset: assert property (
    deep_standby_wake |=> internal_reset && reset_cause[5])
    else $error("deep standby wake gave no reset");
  a_indep_dog_reset: assert property (
    independent_watchdog_underflow || independent_watchdog_refresh_err
    |=> internal_reset && reset_cause[6])
    else $error("independent watchdog gave no reset");
  a_main_dog_reset: assert property (
    main_watchdog_underflow || main_watchdog_refresh_err
    |=> internal_reset && reset_cause[7])
    else $error("main watchdog gave no reset");
  a_sw_key_reset: assert property (
    sw_key |-> ##2 internal_reset && reset_cause[7])
    else $error("software key gave no reset");
  a_irq_single_pulse: assert property (
    irq_any |-> !(maskable_irq && nonmaskable_irq) ##1 !(maskable_irq || nonmaskable_irq))
    else $error("interrupt pulse too long or on both lines");
  a_release_all_clear: assert property (
    $fell(internal_reset) |-> $past(external_reset_pin_n) && $past(supply_above_por)
      && !$past(deep_standby_wake) && !$past(independent_watchdog_underflow)
      && !$past(independent_watchdog_refresh_err)
      && !$past(main_watchdog_underflow) && !$past(main_watchdog_refresh_err))
    else $error("reset released while a source was active");
endmodule : reset_monitor_sva
bind reset_monitor reset_monitor_sva #(.POR_CYC(POR_CYC), .MON_CYC(MON_CYC)) chk (.*);
`default_nettype wire

// ===== verification/reset_monitor_bench.sv
// Self-checking bench for the reset monitor
`timescale 1ns/10ps
`default_nettype none
module reset_monitor_bench
  import reset_monitor_pkg::*;
;
  localparam int POR_CYC = 20;
  localparam int MON_CYC = 10;
  localparam int TICK = 4;
  logic clock, sys_rst, external_reset_pin_n, supply_above_por, ch0_reset_opt;
  logic ch0_below, ch1_below, ch2_below, deep_standby_wake, wr_stb, rd_stb;
  logic independent_watchdog_underflow, independent_watchdog_refresh_err;
  logic main_watchdog_underflow, main_watchdog_refresh_err, low_speed_onchip_osc_tick;
  logic internal_reset, maskable_irq, nonmaskable_irq, event_link_1, event_link_2;
  logic [7:0]  addr, reset_cause;
  logic [31:0] wdata, rdata, d;
  int          fail_count = 0, checks_done = 0, n, s;
  int          cbit[6] = '{0, 5, 6, 6, 7, 7};
  reset_monitor #(.POR_CYC(POR_CYC), .MON_CYC(MON_CYC)) dut (.*);
  osc_tick_model #(.PERIOD(TICK)) osc (.clock(clock), .tick(low_speed_onchip_osc_tick));
  // ==========================================================================
  // Access and compare tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a; wdata <= v; wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a; rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask : rd
  function automatic logic sig(input int sel);
    case (sel)
      0: return internal_reset;
      1: return maskable_irq;
      default: return nonmaskable_irq;
    endcase
  endfunction : sig
  // Bounded wait; the caller judges the count, a timeout is not always a fault
  task automatic wait_lvl(input int sel, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    #1;
    while (sig(sel) !== lvl && cnt < lim) begin
      @(posedge clock);
      #1;
      cnt++;
    end
  endtask : wait_lvl
  task automatic src(input int i, input logic v);
    case (i)
      0: external_reset_pin_n <= !v;
      1: deep_standby_wake <= v;
      2: independent_watchdog_underflow <= v;
      3: independent_watchdog_refresh_err <= v;
      4: main_watchdog_underflow <= v;
      default: main_watchdog_refresh_err <= v;
    endcase
  endtask : src
  task automatic results();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // ==========================================================================
  // Clock, reset and watchdog
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #2_000_000;
    fail_count++;
    results();
  end
  initial begin
    {sys_rst, external_reset_pin_n, supply_above_por} = 3'b111;
    {ch0_below, ch1_below, ch2_below, ch0_reset_opt, deep_standby_wake} = 5'h0;
    {independent_watchdog_underflow, independent_watchdog_refresh_err} = 2'b00;
    {main_watchdog_underflow, main_watchdog_refresh_err, wr_stb, rd_stb} = 4'h0;
    addr = 8'h00; wdata = 32'h0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    wait_lvl(0, 1'b0, POR_CYC + 20, n);
    check(32'(n >= POR_CYC && n < POR_CYC + 20), 1);
    rd(8'h20, d);
    check(d, 32'h0);
    rd(ADDR_CTRL, d);
    check(d, 32'h0);
    @(posedge clock);
    supply_above_por <= 1'b0;
    wait_lvl(0, 1'b1, 5, n);
    check(32'(n < 5), 1);
    @(posedge clock);
    supply_above_por <= 1'b1;
    wait_lvl(0, 1'b0, POR_CYC + 20, n);
    check(32'(n >= POR_CYC), 1);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      src(i, 1'b1);
      @(posedge clock);
      src(i, 1'b0);
      #1;
      check(internal_reset, 1);
      check(reset_cause[cbit[i]], 1);
      wait_lvl(0, 1'b0, POR_CYC + 20, n);
      check(32'(n < POR_CYC + 20), 1);
    end
    wr(ADDR_SW_RESET, 32'h5a);
    wait_lvl(0, 1'b1, 6, n);
    check(n, 6);
    wr(ADDR_SW_RESET, 32'ha5);
    wait_lvl(0, 1'b1, 6, n);
    check(32'(n < 6), 1);
    wait_lvl(0, 1'b0, 20, n);
    @(posedge clock);
    ch0_below <= 1'b1;
    wait_lvl(0, 1'b1, 8, n);
    check(n, 8);
    @(posedge clock);
    ch0_reset_opt <= 1'b1;
    wait_lvl(0, 1'b1, 8, n);
    check(32'(n < 8), 1);
    @(posedge clock);
    ch0_below <= 1'b0;
    wait_lvl(0, 1'b0, MON_CYC + 20, n);
    check(32'(n >= MON_CYC && n < MON_CYC + 20), 1);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CH1_CFG, m ? 32'h11 : 32'h01);
      ch1_below <= 1'b1;
      wait_lvl(0, 1'b1, 20, n);
      check(32'(n < 20), 1);
      @(posedge clock);
      ch1_below <= 1'b0;
      wait_lvl(0, 1'b0, MON_CYC + 20, n);
      check(32'(m ? n < MON_CYC : n >= MON_CYC), 1);
    end
    rd(ADDR_STATUS, d);
    check(d[ST_RST + 4], 1);
    for (int k = 0; k < 4; k++) begin
      s = TICK << (k + 1);
      wr(ADDR_CH1_CFG, {24'h0, k[1:0], 6'h22});
      ch1_below <= 1'b1;
      wait_lvl(1, 1'b1, 5 * s + 12, n);
      // Three agreeing samples one sample period apart, then two register stages
      check(32'(n >= 2 * s && n <= 3 * s + 4), 1);
      check(event_link_1, 1);
      rd(ADDR_STATUS, d);
      check(d[ST_FLAG1], 1);
      wr(ADDR_CTRL, 32'h1);
      ch1_below <= 1'b0;
      repeat (5 * s + 12) @(posedge clock);
      rd(ADDR_STATUS, d);
      check(d[ST_FLAG1], 0);
    end
    wr(ADDR_CH2_CFG, 32'h0e);
    ch2_below <= 1'b1;
    wait_lvl(2, 1'b1, 10, n);
    check(n, 10);
    @(posedge clock);
    ch2_below <= 1'b0;
    wait_lvl(2, 1'b1, 10, n);
    check(32'(n < 10), 1);
    check(maskable_irq, 0);
    check(event_link_2, 1);
    results();
  end
endmodule : reset_monitor_bench
`default_nettype wire
